// >>> dpdbs_pkg.sv
// Shared constants and carrier types of the burst SRAM link
package dpdbs_pkg;

  // ----------------------------------------------------------------
  // Burst and word layout
  // ----------------------------------------------------------------
  localparam int BURST_LEN = 4;
  localparam int LANE_W = 9;
  localparam int WORD_W_NARROW = 18;
  localparam int WORD_W_WIDE = 36;
  localparam int ADDR_W_DEF = 8;

  // ----------------------------------------------------------------
  // Read latency, counted in link edges (both clock phases)
  // ----------------------------------------------------------------
  // Two and a half primary cycles are five half-cycle edges
  localparam int LAT_BYPASS_HI_EDGES = 5;
  localparam int LAT_BYPASS_LO_EDGES = 2;
  localparam int LAT_MAX_EDGES = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic PHASE_RST = 1'b0;
  localparam logic ECHO_RST = 1'b0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic k_rise;
    logic kn_rise;
  } dpdbs_edge_t;

  typedef struct packed {
    logic true_clk;
    logic comp_clk;
  } dpdbs_echo_t;

endpackage : dpdbs_pkg

// >>> dpdbs_sync.sv
// Two-stage synchroniser for the pins of the link
`timescale 1ns/1ps
module dpdbs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // First stage feeds only the second one
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule : dpdbs_sync

// >>> dpdbs_array.sv
// Storage array with self-timed burst commit and pending-write bypass
`timescale 1ns/1ps
module dpdbs_array #(
  parameter int ADDR_W = dpdbs_pkg::ADDR_W_DEF,
  parameter int WORD_W = dpdbs_pkg::WORD_W_NARROW
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic commit_valid,
  input wire logic [ADDR_W-1:0] commit_addr,
  input wire logic [dpdbs_pkg::BURST_LEN*WORD_W-1:0] commit_data,
  input wire logic [dpdbs_pkg::BURST_LEN*(WORD_W/9)-1:0] commit_be_n,
  input wire logic [ADDR_W+1:0] rd_addr,
  output logic [WORD_W-1:0] rd_data
);

  localparam int BL = WORD_W / dpdbs_pkg::LANE_W;
  localparam int DEPTH = 1 << (ADDR_W + 2);

  // Keep lanes whose select is high, take the new byte elsewhere
  function automatic logic [WORD_W-1:0] lane_merge(
    input logic [WORD_W-1:0] nw,
    input logic [BL-1:0] be_n,
    input logic [WORD_W-1:0] old);
    logic [WORD_W-1:0] r;
    r = old;
    for (int j = 0; j < BL; j++) begin
      if (!be_n[j]) begin
        r[j*dpdbs_pkg::LANE_W +: dpdbs_pkg::LANE_W] =
          nw[j*dpdbs_pkg::LANE_W +: dpdbs_pkg::LANE_W];
      end
    end
    return r;
  endfunction : lane_merge

  // ----------------------------------------------------------------
  // Self-timed commit
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] mem [DEPTH];
  logic pend_q;
  logic [1:0] pend_cnt_q;
  logic [ADDR_W-1:0] pend_addr_q;
  logic [dpdbs_pkg::BURST_LEN*WORD_W-1:0] pend_data_q;
  logic [dpdbs_pkg::BURST_LEN*BL-1:0] pend_be_q;

  wire [ADDR_W+1:0] wr_word_addr = {pend_addr_q, pend_cnt_q};
  wire [WORD_W-1:0] wr_word = pend_data_q[pend_cnt_q*WORD_W +: WORD_W];
  wire [BL-1:0] wr_be = pend_be_q[pend_cnt_q*BL +: BL];

  // One word per clock; the host never has to time the write
  always_ff @(posedge clk) begin
    if (pend_q) begin
      mem[wr_word_addr] <= lane_merge(wr_word, wr_be, mem[wr_word_addr]);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      pend_cnt_q <= 2'h0;
      pend_addr_q <= '0;
      pend_data_q <= '0;
      pend_be_q <= '1;
    end else if (commit_valid) begin
      pend_q <= 1'b1;
      pend_cnt_q <= 2'h0;
      pend_addr_q <= commit_addr;
      pend_data_q <= commit_data;
      pend_be_q <= commit_be_n;
    end else if (pend_q) begin
      pend_cnt_q <= pend_cnt_q + 2'h1;
      pend_q <= (pend_cnt_q != 2'h3);
    end
  end

  // ----------------------------------------------------------------
  // Read with bypass of words not yet committed
  // ----------------------------------------------------------------
  wire [1:0] rd_w = rd_addr[1:0];
  wire rd_pend = pend_q & (rd_addr[ADDR_W+1:2] == pend_addr_q) &
                 (rd_w >= pend_cnt_q);
  wire [WORD_W-1:0] rd_raw = mem[rd_addr];
  wire [WORD_W-1:0] rd_new = pend_data_q[rd_w*WORD_W +: WORD_W];
  wire [BL-1:0] rd_be = pend_be_q[rd_w*BL +: BL];

  assign rd_data = rd_pend ? lane_merge(rd_new, rd_be, rd_raw) : rd_raw;

endmodule : dpdbs_array

// >>> dpdbs_top.sv
// Device side of the burst SRAM link: capture, read schedule, echo clocks
// Operation
// - Separate read-data output and write-data input run concurrently.
// - Each address holds four sequential words, 18 or 36 bits wide.
// - Read and write addresses share one bus, taken on alternate k rises.
// - Burst words move on every rising edge of k and k_n.
// - Only rising edges of k and k_n time anything.
// - Bypass select high gives read data 2.5 cycles after the address.
// - Bypass select low gives read data one cycle after the address.
// - Read-valid flag marks the periods carrying valid read words.
// - Echo clock pair is aligned with read data for host capture.
// - Read and write ports each have their own select to start a transfer.
// - All synchronous inputs are registered by ref_clk in a two-stage synchroniser before use.
// - Read data leaves from output registers timed by link clocks.
// - Writes into the array complete under internal self-timed control.
// - Reads return the newest written data, even mid-write.
`timescale 1ns/1ps
module dpdbs_top #(
  parameter int ADDR_W = dpdbs_pkg::ADDR_W_DEF,
  parameter int WORD_W = dpdbs_pkg::WORD_W_NARROW
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic k,
  input wire logic k_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic [WORD_W-1:0] write_data,
  input wire logic [WORD_W/9-1:0] byte_write_select_n,
  input wire logic pll_bypass_select,
  output logic [WORD_W-1:0] read_data,
  output logic read_valid_flag,
  output dpdbs_pkg::dpdbs_echo_t echo_timing_out
);

  localparam int BL = WORD_W / dpdbs_pkg::LANE_W;
  localparam int SW = 5 + ADDR_W + WORD_W + BL;
  localparam int LM = dpdbs_pkg::LAT_MAX_EDGES;
  localparam int BURST = dpdbs_pkg::BURST_LEN;

  // Only the two documented word widths have a lane layout
  if (WORD_W != dpdbs_pkg::WORD_W_NARROW &&
      WORD_W != dpdbs_pkg::WORD_W_WIDE) begin : g_bad_width
    $error("dpdbs_top: WORD_W must be 18 or 36");
  end
  if (ADDR_W < 1 || ADDR_W > 20) begin : g_bad_addr
    $error("dpdbs_top: ADDR_W out of range");
  end

  // Keep lanes whose select is high, take the new byte elsewhere
  function automatic logic [WORD_W-1:0] lane_merge(
    input logic [WORD_W-1:0] nw,
    input logic [BL-1:0] be_n,
    input logic [WORD_W-1:0] old);
    logic [WORD_W-1:0] r;
    r = old;
    for (int j = 0; j < BL; j++) begin
      if (!be_n[j]) begin
        r[j*dpdbs_pkg::LANE_W +: dpdbs_pkg::LANE_W] =
          nw[j*dpdbs_pkg::LANE_W +: dpdbs_pkg::LANE_W];
      end
    end
    return r;
  endfunction : lane_merge

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_pipe_q <= 2'h0;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end

  wire rst_n = rst_pipe_q[1];

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  // Data and clocks share one synchroniser so they keep their alignment
  wire [SW-1:0] pin_raw = {k, k_n, read_port_select_n,
                           write_port_select_n, pll_bypass_select,
                           addr, write_data, byte_write_select_n};
  logic [SW-1:0] pin_s;

  dpdbs_sync #(
    .WIDTH(SW)
  ) u_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(pin_raw),
    .q(pin_s)
  );

  wire s_k = pin_s[SW-1];
  wire s_kn = pin_s[SW-2];
  wire s_rps_n = pin_s[SW-3];
  wire s_wps_n = pin_s[SW-4];
  wire s_byp = pin_s[SW-5];
  wire [ADDR_W-1:0] s_addr = pin_s[BL+WORD_W +: ADDR_W];
  wire [WORD_W-1:0] s_wd = pin_s[BL +: WORD_W];
  wire [BL-1:0] s_bws_n = pin_s[BL-1:0];

  // ----------------------------------------------------------------
  // Link edges
  // ----------------------------------------------------------------
  logic k_prev_q;
  logic kn_prev_q;
  logic [1:0] warm_q;
  dpdbs_pkg::dpdbs_edge_t edg;

  // Sync stages leave reset at zero; a high pin would look like a rise
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      k_prev_q <= 1'b0;
      kn_prev_q <= 1'b0;
      warm_q <= 2'h0;
    end else begin
      k_prev_q <= s_k;
      kn_prev_q <= s_kn;
      if (warm_q != 2'h3) begin
        warm_q <= warm_q + 2'h1;
      end
    end
  end

  wire warm = (warm_q == 2'h3);
  // Falling edges are never decoded
  assign edg = {warm & s_k & ~k_prev_q,
                warm & s_kn & ~kn_prev_q};
  wire lnk_edge = edg.k_rise | edg.kn_rise;

  // ----------------------------------------------------------------
  // Address slots
  // ----------------------------------------------------------------
  // Even k rises carry the read slot, odd ones the write slot
  logic phase_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= dpdbs_pkg::PHASE_RST;
    end else if (edg.k_rise) begin
      phase_q <= ~phase_q;
    end
  end

  wire rd_take = edg.k_rise & ~phase_q & ~s_rps_n;
  wire wr_take = edg.k_rise & phase_q & ~s_wps_n;

  // ----------------------------------------------------------------
  // Write burst capture
  // ----------------------------------------------------------------
  logic cap_busy_q;
  logic [1:0] cap_idx_q;
  logic [ADDR_W-1:0] cap_addr_q;
  logic [WORD_W-1:0] cap_data_q [BURST];
  logic [BL-1:0] cap_be_q [BURST];
  logic [BURST-1:0] cap_have_q;

  wire cap_word = lnk_edge & cap_busy_q;
  wire cap_last = cap_word & (cap_idx_q == 2'h3);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_busy_q <= 1'b0;
      cap_idx_q <= 2'h0;
      cap_addr_q <= '0;
      cap_have_q <= '0;
    end else begin
      if (cap_word) begin
        cap_idx_q <= cap_idx_q + 2'h1;
        cap_have_q[cap_idx_q] <= 1'b1;
      end
      if (wr_take) begin
        cap_busy_q <= 1'b1;
        cap_idx_q <= 2'h0;
        cap_addr_q <= s_addr;
        cap_have_q <= '0;
      end else if (cap_last) begin
        cap_busy_q <= 1'b0;
      end
    end
  end

  // Capture words need no reset; the have bits guard their use
  always_ff @(posedge ref_clk) begin
    if (cap_word) begin
      cap_data_q[cap_idx_q] <= s_wd;
      cap_be_q[cap_idx_q] <= s_bws_n;
    end
  end

  // The last word goes straight to the array so a write may follow at once
  wire [BURST*WORD_W-1:0] commit_data = {s_wd, cap_data_q[2],
                                         cap_data_q[1], cap_data_q[0]};
  wire [BURST*BL-1:0] commit_be_n = {s_bws_n, cap_be_q[2],
                                     cap_be_q[1], cap_be_q[0]};

  // ----------------------------------------------------------------
  // Read schedule
  // ----------------------------------------------------------------
  logic rp_vld_q [LM];
  logic [ADDR_W-1:0] rp_addr_q [LM];
  logic rb_busy_q;
  logic [1:0] rb_idx_q;
  logic [ADDR_W-1:0] rb_addr_q;

  wire [2:0] lat_slot = s_byp ?
    3'(dpdbs_pkg::LAT_BYPASS_HI_EDGES - 1) :
    3'(dpdbs_pkg::LAT_BYPASS_LO_EDGES - 1);

  // A read waits in the slot line and starts when it leaves slot zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LM; i++) begin
        rp_vld_q[i] <= 1'b0;
        rp_addr_q[i] <= '0;
      end
    end else if (lnk_edge) begin
      for (int i = 0; i < LM; i++) begin
        if (rd_take && lat_slot == 3'(i)) begin
          rp_vld_q[i] <= 1'b1;
          rp_addr_q[i] <= s_addr;
        end else if (i == LM - 1) begin
          rp_vld_q[i] <= 1'b0;
        end else begin
          rp_vld_q[i] <= rp_vld_q[i+1];
          rp_addr_q[i] <= rp_addr_q[i+1];
        end
      end
    end
  end

  wire rb_start = lnk_edge & rp_vld_q[0];
  wire rb_next = lnk_edge & ~rp_vld_q[0] & rb_busy_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rb_busy_q <= 1'b0;
      rb_idx_q <= 2'h0;
      rb_addr_q <= '0;
    end else if (rb_start) begin
      rb_busy_q <= 1'b1;
      rb_idx_q <= 2'h1;
      rb_addr_q <= rp_addr_q[0];
    end else if (rb_next) begin
      rb_idx_q <= rb_idx_q + 2'h1;
      rb_busy_q <= (rb_idx_q != 2'h3);
    end
  end

  // ----------------------------------------------------------------
  // Word fetch with coherency
  // ----------------------------------------------------------------
  wire [1:0] sel_idx = rp_vld_q[0] ? 2'h0 : rb_idx_q;
  wire [ADDR_W-1:0] sel_addr = rp_vld_q[0] ? rp_addr_q[0] : rb_addr_q;
  wire [WORD_W-1:0] arr_word;

  dpdbs_array #(
    .ADDR_W(ADDR_W),
    .WORD_W(WORD_W)
  ) u_array (
    .clk(ref_clk),
    .rst_n(rst_n),
    .commit_valid(cap_last),
    .commit_addr(cap_addr_q),
    .commit_data(commit_data),
    .commit_be_n(commit_be_n),
    .rd_addr({sel_addr, sel_idx}),
    .rd_data(arr_word)
  );

  // Captured words are newer than anything in the array
  wire addr_hit = (cap_addr_q == sel_addr);
  wire cap_hit = cap_have_q[sel_idx] & addr_hit;
  wire new_hit = cap_last & (sel_idx == 2'h3) & addr_hit;
  wire [WORD_W-1:0] fetch_word = new_hit ?
    lane_merge(s_wd, s_bws_n, arr_word) :
    cap_hit ? lane_merge(cap_data_q[sel_idx], cap_be_q[sel_idx],
                         arr_word) : arr_word;

  // ----------------------------------------------------------------
  // Output registers and echo clocks
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] read_data_q;
  logic read_valid_q;
  logic echo_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_data_q <= '0;
      read_valid_q <= 1'b0;
    end else if (lnk_edge) begin
      read_valid_q <= rp_vld_q[0] | rb_busy_q;
      if (rp_vld_q[0] || rb_busy_q) begin
        read_data_q <= fetch_word;
      end
    end
  end

  // Echo follows the same edges that launch the data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      echo_q <= dpdbs_pkg::ECHO_RST;
    end else if (edg.k_rise) begin
      echo_q <= 1'b1;
    end else if (edg.kn_rise) begin
      echo_q <= 1'b0;
    end
  end

  assign read_data = read_data_q;
  assign read_valid_flag = read_valid_q;
  assign echo_timing_out = {echo_q, ~echo_q};

endmodule : dpdbs_top

// >>> dpdbs_checker.sv
// Assertion checker for the device side of the burst SRAM link
`timescale 1ns/1ps
module dpdbs_checker #(
  parameter int WORD_W = 18
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic k,
  input wire logic read_port_select_n,
  input wire logic [WORD_W-1:0] read_data,
  input wire logic read_valid_flag,
  input wire dpdbs_pkg::dpdbs_echo_t echo_timing_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [4:0] age_q;
  logic [5:0] word_q;
  logic armed_q = 1'b0;
  // ------------
  // Helper logic
  // ------------
  // Age saturates so a stale request cannot excuse a late burst
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) age_q <= 5'h1F;
    else if (!read_port_select_n) age_q <= 5'h00;
    else if (age_q != 5'h1F) age_q <= age_q + 5'h01;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) word_q <= 6'h00;
    else if (!read_valid_flag) word_q <= 6'h00;
    else if ($changed(echo_timing_out)) word_q <= word_q + 6'h01;
  end
  // Outputs take their reset values one edge after power-on
  always_ff @(posedge ref_clk) armed_q <= 1'b1;
  // ----------
  // Assertions
  // ----------
  a_echo_pair_inverse:
    assert property (echo_timing_out.comp_clk == !echo_timing_out.true_clk)
    else $error("echo pair not complementary");
  a_echo_rising_only:
    assert property ($changed(echo_timing_out.true_clk) |->
      echo_timing_out.true_clk == $past(k, 2))
    else $error("echo level does not follow link clock rise");
  a_data_on_edge:
    assert property (!$changed(echo_timing_out) |-> $stable(read_data))
    else $error("read data moved between link edges");
  a_valid_on_edge:
    assert property ($changed(read_valid_flag) |-> $changed(echo_timing_out))
    else $error("valid flag moved between link edges");
  a_burst_whole:
    assert property ($fell(read_valid_flag) |->
      word_q[1:0] == 2'h0 && word_q != 6'h00)
    else $error("valid window not a whole number of bursts");
  a_reset_quiet:
    assert property (disable iff (1'b0) !nrst && armed_q |->
      read_data == '0 && !read_valid_flag && echo_timing_out == 2'h1)
    else $error("outputs not at reset values");
  a_edge_spacing:
    assert property ($changed(echo_timing_out) |=>
      $stable(echo_timing_out)[*3])
    else $error("link edges closer than half a link period");
  a_read_requested:
    assert property ($rose(read_valid_flag) |-> age_q <= 5'h1C)
    else $error("read burst without a recent read select");
endmodule : dpdbs_checker

bind dpdbs_top dpdbs_checker #(.WORD_W(WORD_W)) dpdbs_checker_i (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .k(k),
  .read_port_select_n(read_port_select_n),
  .read_data(read_data),
  .read_valid_flag(read_valid_flag),
  .echo_timing_out(echo_timing_out)
);

// >>> dpdbs_host.sv
// Behavioural memory controller driving the link pins
`timescale 1ns/1ps
module dpdbs_host #(
  parameter int AW = 8,
  parameter int WW = 18
) (
  output logic k,
  output logic k_n,
  output logic [AW-1:0] addr,
  output logic read_port_select_n,
  output logic write_port_select_n,
  output logic [WW-1:0] write_data,
  output logic [WW/9-1:0] byte_write_select_n
);
  logic run = 1'b0;
  int kcnt = 0;
  longint t_rd = 0;
  // ----------
  // Link clock
  // ----------
  // Odd start offset keeps the link clock off the ref_clk grid
  initial begin
    {k, k_n} = 2'h1;
    {addr, read_port_select_n, write_port_select_n} = '1;
    write_data = '0;
    byte_write_select_n = '1;
    #13;
    forever begin
      #200;
      if (run) {k, k_n} = {k_n, k};
    end
  end
  always @(posedge k) kcnt++;
  task start;
    kcnt = 0;
    run = 1'b1;
  endtask : start
  task halt;
    @(negedge k);
    run = 1'b0;
  endtask : halt
  // Read slot then write slot; write words trail into the next call
  task automatic cycle(input logic rd, input logic [AW-1:0] ra,
      input logic wr, input logic [AW-1:0] wa, input logic [WW-1:0] wb,
      input logic [WW/9-1:0] be);
    do @(posedge k_n); while (kcnt[0]);
    #150;
    addr = ra;
    read_port_select_n = ~rd;
    @(posedge k);
    t_rd = $time;
    #150;
    addr = wa;
    read_port_select_n = 1'b1;
    write_port_select_n = ~wr;
    @(posedge k);
    fork
      begin
        for (int i = 0; i < 4; i++) begin
          #150;
          write_data = wb + WW'(i);
          byte_write_select_n = be;
          #50;
        end
        #100;
        write_data = ~write_data;
      end
    join_none
    #150;
    write_port_select_n = 1'b1;
    addr = ~wa;
  endtask : cycle
endmodule : dpdbs_host

// >>> dpdbs_top_tb.sv
// Self-checking bench for the burst SRAM link device
`timescale 1ns/1ps
module dpdbs_top_tb;
  typedef struct packed {
    logic rd;
    logic [7:0] ra;
    logic wr;
    logic [7:0] wa;
    logic [17:0] wb;
    logic [17:0] eb;
  } dpdbs_row_t;
  dpdbs_row_t rows [6] = '{
    '{1'b0, 8'h00, 1'b1, 8'h10, 18'h01000, 18'h00000},
    '{1'b0, 8'h00, 1'b1, 8'hFF, 18'h02000, 18'h00000},
    '{1'b1, 8'h10, 1'b1, 8'h30, 18'h03000, 18'h01000},
    '{1'b1, 8'hFF, 1'b0, 8'h10, 18'h3FFF0, 18'h02000},
    '{1'b1, 8'h30, 1'b0, 8'h00, 18'h00000, 18'h03000},
    '{1'b1, 8'h10, 1'b0, 8'h00, 18'h00000, 18'h01000}};
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic bypass = 1'b1;
  logic k, k_n, rps_n, wps_n, read_valid_flag, valid_prev;
  logic [7:0] addr;
  logic [17:0] wd, read_data;
  logic [1:0] bws_n;
  dpdbs_pkg::dpdbs_echo_t echo, echo_prev;
  logic [31:0] rq[$], expq[$];
  int checks = 0;
  int bad_count = 0;
  int lat = 0;
  dpdbs_host host_i (.k(k), .k_n(k_n), .addr(addr),
    .read_port_select_n(rps_n), .write_port_select_n(wps_n),
    .write_data(wd), .byte_write_select_n(bws_n));
  dpdbs_top dpdbs_top_i (.ref_clk(ref_clk), .nrst(nrst), .k(k), .k_n(k_n),
    .addr(addr), .read_port_select_n(rps_n), .write_port_select_n(wps_n),
    .write_data(wd), .byte_write_select_n(bws_n),
    .pll_bypass_select(bypass), .read_data(read_data),
    .read_valid_flag(read_valid_flag), .echo_timing_out(echo));
  always #25 ref_clk = ~ref_clk;
  // --------------
  // Burst capture
  // --------------
  always @(negedge ref_clk) begin
    if (read_valid_flag && echo !== echo_prev) rq.push_back(32'(read_data));
    if (read_valid_flag && !valid_prev) lat = int'(($time - host_i.t_rd) / 200);
    echo_prev = echo;
    valid_prev = read_valid_flag;
  end
  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic drain(input string name);
    repeat (60) @(posedge ref_clk);
    check(name, 32'(rq.size()), 32'(expq.size()));
    while (rq.size() > 0 && expq.size() > 0)
      check(name, rq.pop_front(), expq.pop_front());
    rq.delete();
    expq.delete();
    $display("done %s", name);
  endtask : drain
  task automatic rst(input logic byp);
    @(posedge ref_clk);
    #1 nrst = 1'b0;
    bypass = byp;
    repeat (10) @(posedge ref_clk);
    check("data", 32'(read_data), 32'h0);
    check("valid", 32'(read_valid_flag), 32'h0);
    check("echo", 32'(echo), 32'h1);
    #1 nrst = 1'b1;
    repeat (8) @(posedge ref_clk);
    host_i.start();
    $display("done reset");
  endtask : rst
  task automatic results;
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  // ------
  // Tests
  // ------
  // Whole run is near 20 us, so the limit leaves ample margin
  initial begin
    #200000;
    bad_count++;
    results();
  end
  initial begin
    rst(1'b1);
    foreach (rows[i]) begin
      host_i.cycle(rows[i].rd, rows[i].ra, rows[i].wr, rows[i].wa,
        rows[i].wb, 2'h0);
      for (int j = 0; j < 4 && rows[i].rd; j++)
        expq.push_back(32'(rows[i].eb + 18'(j)));
    end
    drain("rows");
    host_i.cycle(1'b0, 8'h00, 1'b1, 8'h10, 18'h3FFF0, 2'h1);
    host_i.cycle(1'b1, 8'h10, 1'b0, 8'h00, 18'h00000, 2'h0);
    for (int j = 0; j < 4; j++)
      expq.push_back(32'((18'h3FFF0 & 18'h3FE00) |
        ((18'h01000 + 18'(j)) & 18'h001FF)));
    drain("lanes");
    check("lat hi", 32'(lat), 32'h5);
    host_i.halt();
    rst(1'b0);
    host_i.cycle(1'b0, 8'h00, 1'b1, 8'h20, 18'h05000, 2'h0);
    // First read follows the write at once, while its words are in capture
    host_i.cycle(1'b1, 8'h20, 1'b0, 8'h00, 18'h00000, 2'h0);
    host_i.cycle(1'b1, 8'h20, 1'b0, 8'h00, 18'h00000, 2'h0);
    for (int j = 0; j < 8; j++)
      expq.push_back(32'h05000 + 32'(j % 4));
    drain("bypass low");
    check("lat lo", 32'(lat), 32'h2);
    results();
  end
endmodule : dpdbs_top_tb
